// ---- hw/sar_conv_control.sv ----
`timescale 1ns/10ps
// Summary of operation
// - Converter runs only while the enable bit is 1.
// - Enable at 0 means shutdown; no conversions start or continue.
// - Result is a 10-bit unsigned code loaded into high/low bytes at completion.
// - Justify bit 0 right-justifies, 1 left-justifies the result pair.
// - Result bits unused by the chosen format read as zero.
// - Eight-bit mode resolves 8 MSBs into the high result byte.
// - Justify bit is ignored in eight-bit mode.
// - Eight-bit conversions finish two SAR clocks sooner.
// - SAR clock is the system clock divided by the period field plus one.
// - Period field equals system clock over SAR clock, minus one.
// - Start source selects software, timers 0/2/1/3 or external rising edge.
// - Busy reads 1 throughout a conversion, 0 after completion.
// - Busy falling at conversion end (not on disable) sets complete flag and raises the interrupt.
// - Timers 2/3 use low-byte overflow when their timer-mode bit is 1 (split 8-bit), else high-byte.
// - Tracking mode delays conversion start by three SAR clocks while tracking.
// - Tracking mode 0 starts converting immediately on the trigger.
// - Internal sources: track whenever no conversion is in progress.
// - External source: track if tracking bit 1, else only while pin low.
// - In eight-bit mode the low result byte reads zero.
// - Conversion takes 13 SAR clocks (10-bit) or 11 (8-bit).
module sar_conv_control
    import sar_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic timer0_ovf,
    input wire logic timer1_ovf,
    input wire logic timer2_low_ovf,
    input wire logic timer2_high_ovf,
    input wire logic timer3_low_ovf,
    input wire logic timer3_high_ovf,
    input wire logic external_start_input,
    input wire logic [9:0] sar_code,
    input wire logic window_hit,
    output logic conv_power_on,
    output logic sampler_track,
    output logic sar_sample,
    output logic conv_irq
);
    logic [7:0] config_q;
    logic [7:0] control_q;
    logic [1:0] timer_mode_q;
    logic [7:0] result_high_byte;
    logic [7:0] result_low_byte;
    conv_state_t state_q;
    logic [3:0] clk_cnt_q;
    logic busy_q;
    logic done_q;
    logic win_q;
    logic ext_prev_q;
    logic sar_tick;
    logic conv_enable;
    logic tracking_mode_select;
    logic justify_select;
    logic eight_bit_mode_enable;
    logic [4:0] sar_clock_period;
    start_src_t start_source_select;
    logic trigger;
    logic sw_start;
    logic busy_fall;
    logic finish;
    logic [3:0] conv_len;

    assign conv_enable = control_q[CTL_ENABLE_BIT];
    assign tracking_mode_select = control_q[CTL_TRACK_BIT];
    assign start_source_select = start_src_t'(control_q[2:0]);
    assign justify_select = config_q[CFG_JUSTIFY_BIT];
    assign eight_bit_mode_enable = config_q[CFG_EIGHT_BIT];
    assign sar_clock_period = config_q[7:CFG_PERIOD_LSB];
    assign conv_power_on = conv_enable;

    function automatic logic is_write(input logic [2:0] a, input logic [2:0] ofs);
        return wr_en && (a == ofs);
    endfunction

    sar_clock_divider u_div (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .run(conv_enable && state_q != ST_IDLE),
        .period(sar_clock_period),
        .sar_tick(sar_tick)
    );

    assign sw_start = is_write(addr, OFS_CONTROL) && wdata[CTL_BUSY_BIT];

    // Trigger selection
    always_comb begin
        unique case (start_source_select)
            SRC_SOFTWARE: trigger = sw_start;
            SRC_TIMER0: trigger = timer0_ovf;
            SRC_TIMER2: trigger = timer_mode_q[TMODE_T2_BIT] ? timer2_low_ovf
                                                              : timer2_high_ovf;
            SRC_TIMER1: trigger = timer1_ovf;
            SRC_EXT_PIN: trigger = external_start_input && !ext_prev_q;
            SRC_TIMER3: trigger = timer_mode_q[TMODE_T3_BIT] ? timer3_low_ovf
                                                              : timer3_high_ovf;
            default: trigger = 1'b0;
        endcase
    end

    assign conv_len = eight_bit_mode_enable ? CONV_CLKS_8 : CONV_CLKS_10;
    assign finish = state_q == ST_CONVERT && sar_tick && clk_cnt_q == conv_len - 4'h1;
    assign busy_fall = busy_q && (finish || !conv_enable);

    always_ff @(posedge clk) begin
        if (srst) begin
            ext_prev_q <= 1'b0;
        end else if (ce) begin
            ext_prev_q <= external_start_input;
        end
    end

    // Conversion sequencer
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= ST_IDLE;
            clk_cnt_q <= 4'h0;
            busy_q <= 1'b0;
        end else if (ce) begin
            if (!conv_enable) begin
                state_q <= ST_IDLE;
                clk_cnt_q <= 4'h0;
                busy_q <= 1'b0;
            end else begin
                unique case (state_q)
                    ST_IDLE: begin
                        clk_cnt_q <= 4'h0;
                        if (trigger) begin
                            busy_q <= 1'b1;
                            state_q <= tracking_mode_select ? ST_DELAY : ST_CONVERT;
                        end
                    end
                    ST_DELAY: begin
                        if (sar_tick) begin
                            if (clk_cnt_q == TRACK_DELAY_CLKS - 4'h1) begin
                                clk_cnt_q <= 4'h0;
                                state_q <= ST_CONVERT;
                            end else begin
                                clk_cnt_q <= clk_cnt_q + 4'h1;
                            end
                        end
                    end
                    ST_CONVERT: begin
                        if (finish) begin
                            clk_cnt_q <= 4'h0;
                            busy_q <= 1'b0;
                            state_q <= ST_IDLE;
                        end else if (sar_tick) begin
                            clk_cnt_q <= clk_cnt_q + 4'h1;
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // Sampler control
    always_comb begin
        if (state_q == ST_CONVERT) begin
            sampler_track = 1'b0;
        end else if (start_source_select == SRC_EXT_PIN) begin
            sampler_track = tracking_mode_select || !external_start_input;
        end else begin
            sampler_track = 1'b1;
        end
    end
    assign sar_sample = state_q == ST_CONVERT && clk_cnt_q == 4'h0;

    // Result formatting at completion
    always_ff @(posedge clk) begin
        if (srst) begin
            result_high_byte <= 8'h00;
            result_low_byte <= 8'h00;
        end else if (ce) begin
            if (finish) begin
                if (eight_bit_mode_enable) begin
                    result_high_byte <= sar_code[9:2];
                    result_low_byte <= 8'h00;
                end else if (justify_select) begin
                    result_high_byte <= sar_code[9:2];
                    result_low_byte <= {sar_code[1:0], 6'h00};
                end else begin
                    result_high_byte <= {6'h00, sar_code[9:8]};
                    result_low_byte <= sar_code[7:0];
                end
            end else begin
                if (is_write(addr, OFS_HIGH)) begin
                    result_high_byte <= wdata;
                end
                if (is_write(addr, OFS_LOW)) begin
                    result_low_byte <= wdata;
                end
            end
        end
    end

    // Configuration and control registers
    always_ff @(posedge clk) begin
        if (srst) begin
            config_q <= CONFIG_RESET;
            control_q <= CONTROL_RESET;
            timer_mode_q <= 2'h0;
        end else if (ce) begin
            if (is_write(addr, OFS_CONFIG)) begin
                config_q <= wdata;
            end
            if (is_write(addr, OFS_CONTROL)) begin
                control_q <= wdata;
            end
            if (is_write(addr, OFS_TIMER_MODE)) begin
                timer_mode_q <= wdata[1:0];
            end
        end
    end

    // Complete and window flags: set wins over clear
    always_ff @(posedge clk) begin
        if (srst) begin
            done_q <= 1'b0;
            win_q <= 1'b0;
        end else if (ce) begin
            if (busy_fall && finish) begin
                done_q <= 1'b1;
            end else if (is_write(addr, OFS_CONTROL)) begin
                done_q <= wdata[CTL_DONE_BIT];
            end
            if (finish && window_hit) begin
                win_q <= 1'b1;
            end else if (is_write(addr, OFS_CONTROL)) begin
                win_q <= wdata[CTL_WIN_BIT];
            end
        end
    end
    assign conv_irq = done_q;

    // Read port
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= 8'h00;
        end else if (ce) begin
            if (rd_en) begin
                unique case (addr)
                    OFS_CONFIG: rdata <= config_q;
                    OFS_LOW: rdata <= result_low_byte;
                    OFS_HIGH: rdata <= result_high_byte;
                    OFS_CONTROL: rdata <= {control_q[7:6], done_q, busy_q, win_q,
                                           control_q[2:0]};
                    OFS_TIMER_MODE: rdata <= {6'h00, timer_mode_q};
                    default: rdata <= 8'h00;
                endcase
            end else begin
                rdata <= 8'h00;
            end
        end
    end
endmodule

// ---- common/sar_ctrl_pkg.sv ----
package sar_ctrl_pkg;
    // Register offsets on the plain register port
    localparam logic [2:0] OFS_CONFIG = 3'h0;
    localparam logic [2:0] OFS_LOW = 3'h1;
    localparam logic [2:0] OFS_HIGH = 3'h2;
    localparam logic [2:0] OFS_CONTROL = 3'h3;
    localparam logic [2:0] OFS_TIMER_MODE = 3'h4;
    // Configuration register fields
    localparam int CFG_PERIOD_LSB = 3;
    localparam int CFG_JUSTIFY_BIT = 2;
    localparam int CFG_EIGHT_BIT = 1;
    localparam int CFG_GAIN_BIT = 0;
    localparam logic [7:0] CONFIG_RESET = 8'hF8;
    // Control register fields
    localparam int CTL_ENABLE_BIT = 7;
    localparam int CTL_TRACK_BIT = 6;
    localparam int CTL_DONE_BIT = 5;
    localparam int CTL_BUSY_BIT = 4;
    localparam int CTL_WIN_BIT = 3;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    // Timer-mode register fields: 1 means the timer runs split 8-bit
    localparam int TMODE_T2_BIT = 0;
    localparam int TMODE_T3_BIT = 1;
    // Conversion lengths in SAR clocks
    localparam logic [3:0] CONV_CLKS_10 = 4'hD;
    localparam logic [3:0] CONV_CLKS_8 = 4'hB;
    localparam logic [3:0] TRACK_DELAY_CLKS = 4'h3;
    localparam int RESULT_WIDTH = 10;

    typedef enum logic [2:0] {
        SRC_SOFTWARE = 3'b000,
        SRC_TIMER0 = 3'b001,
        SRC_TIMER2 = 3'b010,
        SRC_TIMER1 = 3'b011,
        SRC_EXT_PIN = 3'b100,
        SRC_TIMER3 = 3'b101
    } start_src_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DELAY = 2'b01,
        ST_CONVERT = 2'b10
    } conv_state_t;
endpackage

// ---- hw/sar_clock_divider.sv ----
`timescale 1ns/10ps
module sar_clock_divider
    import sar_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic run,
    input wire logic [4:0] period,
    output logic sar_tick
);
    logic [4:0] div_q;

    // One tick every period+1 system clocks
    always_ff @(posedge clk) begin
        if (srst || !run) begin
            div_q <= 5'h00;
        end else if (ce) begin
            if (div_q >= period) begin
                div_q <= 5'h00;
            end else begin
                div_q <= div_q + 5'h01;
            end
        end
    end

    assign sar_tick = run && ce && (div_q >= period);
endmodule

// ---- verification/sar_analog_model.sv ----
`timescale 1ns/10ps
// Analog SAR core: resolves the input level at the sample point
module sar_analog_model (
    input wire logic clk,
    input wire logic sar_sample,
    input wire logic [9:0] level,
    output logic [9:0] sar_code
);
    always_ff @(posedge clk) begin
        if (sar_sample) begin
            sar_code <= level;
        end
    end
endmodule

// ---- verification/sar_conv_control_checker.sv ----
`timescale 1ns/10ps
module sar_conv_control_checker
    import sar_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire logic conv_power_on,
    input wire logic sampler_track,
    input wire logic sar_sample,
    input wire logic conv_irq
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (srst);
    wire ctl_wr = wr_en && addr == OFS_CONTROL;
    a_power_follows_enable: assert property (
        ctl_wr |=> conv_power_on == $past(wdata[CTL_ENABLE_BIT])) else $error("enable lost");
    a_no_sample_off: assert property (
        !conv_power_on |-> !sar_sample) else $error("sample while off");
    a_done_needs_power: assert property (
        $rose(conv_irq) && !$past(wr_en) && !$past(wr_en, 2) |-> conv_power_on)
        else $error("done while off");
    a_reset_state: assert property (
        $past(srst) |-> sampler_track && !conv_irq && !conv_power_on) else $error("bad reset");
    a_sample_not_track: assert property (
        sar_sample |-> !sampler_track) else $error("track during sample");
    a_done_holds: assert property (
        conv_irq && !ctl_wr |=> conv_irq) else $error("done dropped");
    a_done_after_conv: assert property (
        $rose(conv_irq) && !$past(wr_en) |-> !$past(sampler_track)) else $error("early done");
    a_status_read: assert property (
        $past(rd_en) && $past(addr) == OFS_CONTROL |-> rdata[CTL_DONE_BIT] == $past(conv_irq)
        && rdata[CTL_ENABLE_BIT] == $past(conv_power_on)) else $error("bad status");
    c_sample: cover property (sar_sample);
    c_done: cover property ($rose(conv_irq));
    c_track_off: cover property ($fell(sampler_track));
endmodule
bind sar_conv_control sar_conv_control_checker chk_i (.clk(clk), .srst(srst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .conv_power_on(conv_power_on),
    .sampler_track(sampler_track), .sar_sample(sar_sample), .conv_irq(conv_irq));

// ---- verification/sar_conv_control_tb_top.sv ----
`timescale 1ns/10ps
module sar_conv_control_tb_top;
    import sar_ctrl_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [6:0] trig = 7'h00;
    logic [9:0] level = 10'h000;
    logic [7:0] rdata;
    logic [9:0] sar_code;
    logic power_on, track, sample, irq;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    initial begin
        forever #5 clk = ~clk;
    end
    sar_conv_control uut (.clk(clk), .srst(srst), .ce(1'b1), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .timer0_ovf(trig[0]),
        .timer1_ovf(trig[1]), .timer2_low_ovf(trig[2]), .timer2_high_ovf(trig[3]),
        .timer3_low_ovf(trig[4]), .timer3_high_ovf(trig[5]),
        .external_start_input(trig[6]), .sar_code(sar_code), .window_hit(1'b0),
        .conv_power_on(power_on), .sampler_track(track), .sar_sample(sample), .conv_irq(irq));
    sar_analog_model far_i (.clk(clk), .sar_sample(sample), .level(level), .sar_code(sar_code));
    task automatic final_report;
        $display("mismatches %0d, checks_done %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(input logic [6:0] m);
        @(posedge clk);
        trig <= m;
        @(posedge clk);
        trig <= 7'h00;
    endtask
    task automatic conv(input logic [7:0] cfg, input logic [7:0] trk, input logic [9:0] lvl,
        input int n, input logic [15:0] res);
        int k;
        k = 0;
        wr(OFS_CONFIG, cfg);
        wr(OFS_CONTROL, 8'h80 | trk);
        level <= lvl;
        wr(OFS_CONTROL, 8'h90 | trk);
        #1;
        while (irq !== 1'b1 && k < 300) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk(16'(k), 16'(n));
        rdc(OFS_HIGH, res[15:8]);
        rdc(OFS_LOW, res[7:0]);
        rdc(OFS_CONTROL, 8'hA0 | trk);
    endtask
    task automatic src_case(input logic [2:0] s, input logic [6:0] bad, input logic [6:0] good);
        wr(OFS_CONTROL, 8'h80 | s);
        pulse(bad);
        ticks(20);
        chk(irq, 1'b0);
        pulse(good);
        ticks(20);
        chk(irq, 1'b1);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report;
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        rdc(OFS_CONFIG, CONFIG_RESET);
        rdc(OFS_CONTROL, CONTROL_RESET);
        rdc(OFS_HIGH, 8'h00);
        rdc(3'h7, 8'h00);
        wr(OFS_CONTROL, 8'h10);
        ticks(20);
        chk(irq, 1'b0);
        chk(power_on, 1'b0);
        conv(8'h00, 8'h00, 10'h3FF, 13, 16'h03FF);
        conv(8'h04, 8'h00, 10'h3FF, 13, 16'hFFC0);
        conv(8'h04, 8'h00, 10'h200, 13, 16'h8000);
        conv(8'h06, 8'h00, 10'h3FF, 11, 16'hFF00);
        conv(8'h10, 8'h00, 10'h155, 39, 16'h0155);
        conv(8'h00, 8'h40, 10'h0AA, 16, 16'h00AA);
        ticks(30);
        chk(irq, 1'b1);
        wr(OFS_CONTROL, 8'h90);
        wr(OFS_CONTROL, 8'h00);
        ticks(20);
        chk(irq, 1'b0);
        rdc(OFS_CONTROL, 8'h00);
        wr(OFS_TIMER_MODE, 8'h00);
        src_case(3'h1, 7'h02, 7'h01);
        src_case(3'h3, 7'h01, 7'h02);
        src_case(3'h2, 7'h04, 7'h08);
        src_case(3'h5, 7'h10, 7'h20);
        src_case(3'h4, 7'h01, 7'h40);
        wr(OFS_TIMER_MODE, 8'h03);
        src_case(3'h2, 7'h08, 7'h04);
        src_case(3'h5, 7'h20, 7'h10);
        wr(OFS_CONTROL, 8'h84);
        trig <= 7'h40;
        ticks(20);
        chk(track, 1'b0);
        @(posedge clk);
        trig <= 7'h00;
        ticks(2);
        chk(track, 1'b1);
        final_report;
    end
endmodule
